// ==== rtbp_pkg.sv ====
/*
 * rtbp_pkg: shared constants, register offsets and carrier types for the reload timer
 * block with buzzer and pwm output.
 * assumes: a classic wishbone slave with 32-bit data and byte addressing.
 */
package rtbp_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses = index * 4)
	// ------------------------------------------------------------
	localparam logic [7:0] RTBP_IDX_RELOAD = 8'hCD;
	localparam logic [7:0] RTBP_IDX_MODE = 8'hDA;
	localparam logic [7:0] RTBP_IDX_COUNT = 8'hDB;
	localparam logic [7:0] RTBP_IDX_FLAGS = 8'hDC;
	localparam logic [7:0] RTBP_RESET_BYTE = 8'h00;
	// ------------------------------------------------------------
	// mode register fields
	// ------------------------------------------------------------
	localparam int RTBP_MODE_PWM = 0;
	localparam int RTBP_MODE_TOGGLE = 1;
	localparam int RTBP_MODE_ALOAD = 2;
	localparam int RTBP_MODE_CKS = 3;
	localparam int RTBP_MODE_RATE_LO = 4;
	localparam int RTBP_MODE_ENB = 7;
	// flags register fields
	localparam int RTBP_FLAG_OVF = 0;
	localparam int RTBP_FLAG_IEN = 1;
	localparam int RTBP_FLAG_PINIRQ = 2;
	// ------------------------------------------------------------
	// counting constants
	// ------------------------------------------------------------
	localparam logic [7:0] RTBP_MASK_256 = 8'hFF;
	localparam logic [7:0] RTBP_MASK_64 = 8'h3F;
	localparam logic [7:0] RTBP_MASK_32 = 8'h1F;
	localparam logic [7:0] RTBP_MASK_16 = 8'h0F;
	localparam logic [7:0] RTBP_PRESCALE_RESET = 8'h00;

	// bus answer state
	typedef enum logic [1:0] {
		RTBP_BUS_IDLE = 2'b01,
		RTBP_BUS_ACK = 2'b10
	} rtbp_bus_type;

	// all register state of the block
	typedef struct packed {
		rtbp_bus_type bus;
		logic [31:0] rdata;
		logic [7:0] mode;
		logic [7:0] count;
		logic [7:0] hold;
		logic [7:0] reload;
		logic [7:0] presc;
		logic ovf;
		logic ien;
		logic pin_irq;
		logic ev_s1;
		logic ev_s2;
		logic ev_s3;
		logic buzz;
		logic pwm;
		logic enb_seen;
		logic wave_oe;
		logic wave_out;
		logic wake_en;
		logic ext_irq_en;
		logic irq;
	} rtbp_state_type;

	// wishbone request carrier
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [31:0] adr;
		logic [31:0] dat;
	} rtbp_wb_req_type;
endpackage : rtbp_pkg

// ==== rtbp_timer.sv ====
/*
 * rtbp_timer: 8-bit up counter with double-buffered reload, event count, buzzer and pwm.
 * assumes: one clock core_clk, inputs synchronous except the event pin, which is
 * synchronised here; a classic wishbone master drives the registers.
 */
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
// Operation
// [R01] overflow loads count from active reload buffer; code loads count from the holding buffer (hold)
// [R02] reload write goes to holding buffer first
// [R03] software sets count equal reload before enabling
// [R04] overflow boundary 256, or 64/32/16 in pwm
// [R05] clock source bit selects event pin
// [R06] event mode counts each falling edge
// [R07] event overflow on full scale to zero
// [R08] event mode suppresses pin wake-up
// [R09] event mode blocks pin irq, flag zero
// [R10] toggle output inverts buzzer each overflow
// [R11] overflow sets flag, irq when enabled
// [R12] toggle enable routes buzzer to pin
// [R13] software keeps pwm off during buzzer use
// [R14] pwm enable with counter drives pwm on pin
// [R15] pwm count starts zero, high first
// [R16] pwm goes low when count equals reload
// [R17] new duty from next cycle, reload forced
// [R18] resolution pair selects 256/64/32/16
// [R19] software rescales duty on resolution change
// [R20] prescale select divides from 256 down to 2
// [R21] counter stops when enable bit is zero
// [R22] timer reload only with auto-reload bit
// [R23] event input synchronised before edge detect
module rtbp_timer (
	input wire logic core_clk,
	input wire logic rst_n,
	input rtbp_pkg::rtbp_wb_req_type wb_req,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic event_input_pin,
	input wire logic external_irq_input,
	input wire logic gpio_out,
	input wire logic gpio_oe,
	output logic wave_output_pin,
	output logic wave_output_oe,
	output logic pin_wake_enable,
	output logic external_irq_enable,
	output logic event_pin_irq_flag,
	output logic overflow_irq
);
	import rtbp_pkg::*;

	rtbp_state_type s_q;
	rtbp_state_type s_d;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// boundary mask from resolution pair
	function automatic logic [7:0] bound_mask(input logic pwm_on, input logic [1:0] res);
		logic [7:0] m;
		m = RTBP_MASK_256;
		if (pwm_on) begin
			unique case (res)
				2'b00: m = RTBP_MASK_256;
				2'b01: m = RTBP_MASK_64;
				2'b10: m = RTBP_MASK_32;
				2'b11: m = RTBP_MASK_16;
			endcase
		end
		return m;
	endfunction : bound_mask

	// prescaler tap: 000 -> /256 ... 111 -> /2
	function automatic logic presc_tick(input logic [7:0] cnt, input logic [2:0] rate);
		logic [7:0] lim;
		lim = 8'hFF >> rate;
		return (cnt & lim) == lim;
	endfunction : presc_tick

	// byte address to register index
	function automatic logic [7:0] reg_index(input logic [31:0] adr);
		return adr[9:2];
	endfunction : reg_index

	logic ev_fall;
	logic tick;
	logic cnt_enb;
	logic cks;
	logic pwm_mode;
	logic [7:0] mask;
	logic at_top;
	logic ovf_evt;
	logic reload_on;
	logic bus_hit;
	logic bus_wr;
	logic [7:0] idx;
	logic [7:0] next_cnt;

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		cnt_enb = s_q.mode[RTBP_MODE_ENB];
		cks = s_q.mode[RTBP_MODE_CKS];
		pwm_mode = s_q.mode[RTBP_MODE_PWM] & ~cks;
		mask = bound_mask(pwm_mode, {s_q.mode[RTBP_MODE_ALOAD], s_q.mode[RTBP_MODE_TOGGLE]}); // [R04] [R18]
		// synchroniser, second stage onward feeds edge detect
		s_d.ev_s1 = event_input_pin; // [R23]
		s_d.ev_s2 = s_q.ev_s1;
		s_d.ev_s3 = s_q.ev_s2;
		ev_fall = s_q.ev_s3 & ~s_q.ev_s2; // [R06] [R23]
		// prescaler runs freely while enabled
		s_d.presc = cnt_enb ? s_q.presc + 8'h01 : RTBP_PRESCALE_RESET;
		// clock source pick, rate ignored for event pin
		tick = cnt_enb & (cks ? ev_fall : presc_tick(s_q.presc, s_q.mode[6:4])); // [R05] [R20] [R21]
		at_top = (s_q.count & mask) == mask;
		ovf_evt = tick & at_top; // [R07]
		reload_on = pwm_mode | s_q.mode[RTBP_MODE_ALOAD]; // [R17] [R22]
		next_cnt = (s_q.count + 8'h01) & mask;
		if (tick) begin
			if (ovf_evt && pwm_mode) begin
				s_d.count = 8'h00; // [R15]
			end else if (ovf_evt && reload_on) begin
				s_d.count = s_q.hold; // [R01]
			end else begin
				s_d.count = next_cnt;
			end
		end
		// holding buffer moves to active buffer at overflow
		if (ovf_evt) begin
			s_d.reload = s_q.hold; // [R02] [R17]
		end
		// buzzer toggles each overflow while the toggle bit is set and pwm mode is off
		if (ovf_evt && s_q.mode[RTBP_MODE_TOGGLE] && !pwm_mode) begin
			s_d.buzz = ~s_q.buzz; // [R10]
		end
		// pwm: high at cycle start, low on match
		s_d.enb_seen = cnt_enb;
		if (pwm_mode && cnt_enb && !s_q.enb_seen) begin
			s_d.pwm = 1'b1; // [R15]
			s_d.count = 8'h00;
		end else if (ovf_evt) begin
			s_d.pwm = 1'b1; // [R15]
		end else if (tick && (next_cnt == (s_q.reload & mask))) begin
			s_d.pwm = 1'b0; // [R16]
		end
		// bus decode
		idx = reg_index(wb_req.adr);
		bus_hit = wb_req.cyc & wb_req.stb & (s_q.bus == RTBP_BUS_IDLE);
		bus_wr = bus_hit & wb_req.we & wb_req.sel[0];
		unique case (s_q.bus)
			RTBP_BUS_IDLE: begin
				if (bus_hit) begin
					s_d.bus = RTBP_BUS_ACK;
				end
			end
			RTBP_BUS_ACK: begin
				s_d.bus = RTBP_BUS_IDLE;
			end
		endcase
		if (bus_wr) begin
			unique case (idx)
				RTBP_IDX_RELOAD: s_d.hold = wb_req.dat[7:0]; // [R02]
				RTBP_IDX_MODE: s_d.mode = wb_req.dat[7:0];
				RTBP_IDX_COUNT: s_d.count = wb_req.dat[7:0];
				RTBP_IDX_FLAGS: s_d.ien = wb_req.dat[RTBP_FLAG_IEN];
				default: s_d.ien = s_d.ien;
			endcase
		end
		// overflow flag: set wins over software clear
		if (bus_wr && idx == RTBP_IDX_FLAGS && !wb_req.dat[RTBP_FLAG_OVF]) begin
			s_d.ovf = 1'b0;
		end
		if (bus_wr && idx == RTBP_IDX_FLAGS && !wb_req.dat[RTBP_FLAG_PINIRQ]) begin
			s_d.pin_irq = 1'b0;
		end
		if (ovf_evt) begin
			s_d.ovf = 1'b1; // [R11]
		end
		s_d.irq = s_d.ovf & s_d.ien; // [R11]
		// pin external interrupt, blocked in event mode
		if (external_irq_input && !cks) begin
			s_d.pin_irq = 1'b1;
		end
		if (cks) begin
			s_d.pin_irq = 1'b0; // [R09]
		end
		s_d.ext_irq_en = ~cks; // [R09]
		s_d.wake_en = ~cks; // [R08]
		// read data
		s_d.rdata = 32'h0000_0000;
		if (bus_hit && !wb_req.we) begin
			unique case (idx)
				RTBP_IDX_MODE: s_d.rdata = {24'h00_0000, s_q.mode};
				RTBP_IDX_COUNT: s_d.rdata = {24'h00_0000, s_q.count};
				RTBP_IDX_FLAGS: s_d.rdata = {29'h0, s_q.pin_irq, s_q.ien, s_q.ovf};
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end
		// shared pin mux: pwm, then buzzer, else gpio
		if (s_q.mode[RTBP_MODE_PWM] && cnt_enb) begin
			s_d.wave_out = s_d.pwm; // [R14]
			s_d.wave_oe = 1'b1;
		end else if (s_q.mode[RTBP_MODE_TOGGLE] && !s_q.mode[RTBP_MODE_PWM]) begin
			s_d.wave_out = s_d.buzz; // [R12]
			s_d.wave_oe = 1'b1;
		end else begin
			s_d.wave_out = gpio_out; // [R12] [R14]
			s_d.wave_oe = gpio_oe;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{bus: RTBP_BUS_IDLE, mode: RTBP_RESET_BYTE, count: RTBP_RESET_BYTE,
				hold: RTBP_RESET_BYTE, reload: RTBP_RESET_BYTE, presc: RTBP_PRESCALE_RESET,
				ev_s1: 1'b1, ev_s2: 1'b1, ev_s3: 1'b1, pwm: 1'b1, wake_en: 1'b1,
				ext_irq_en: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// outputs from flip-flops
	assign wb_dat_o = s_q.rdata;
	assign wb_ack_o = (s_q.bus == RTBP_BUS_ACK);
	assign wave_output_pin = s_q.wave_out;
	assign wave_output_oe = s_q.wave_oe;
	assign pin_wake_enable = s_q.wake_en;
	assign external_irq_enable = s_q.ext_irq_en;
	assign event_pin_irq_flag = s_q.pin_irq;
	assign overflow_irq = s_q.irq;
endmodule : rtbp_timer

// ==== rtbp_sva.sv ====
/* rtbp_sva: port checks for the reload timer block.
 assumes: bound to rtbp_timer, one clock domain. */
`timescale 1ns/1ps
module rtbp_sva (
	input wire logic core_clk,
	input wire logic rst_n,
	input rtbp_pkg::rtbp_wb_req_type wb_req,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic external_irq_input,
	input wire logic pin_wake_enable,
	input wire logic external_irq_enable,
	input wire logic event_pin_irq_flag
);
	import rtbp_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	sequence s_req; wb_req.cyc && wb_req.stb && !wb_ack_o; endsequence
	sequence s_pin_irq; (external_irq_input && external_irq_enable) [*3]; endsequence
	property p_ack; s_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
	property p_no_ack; !(wb_req.cyc && wb_req.stb) && !wb_ack_o |=> !wb_ack_o; endproperty
	property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	property p_dat_byte; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
	property p_wo; wb_ack_o && !$past(wb_req.we) && $past(wb_req.adr) == 32'h334
		|-> wb_dat_o == 32'h0; endproperty
	property p_wake; pin_wake_enable == external_irq_enable; endproperty
	property p_flag0; !external_irq_enable && $past(!external_irq_enable)
		|-> !event_pin_irq_flag; endproperty
	property p_flag1; s_pin_irq |-> ##[0:2] event_pin_irq_flag; endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle after request");
	a_no_ack: assert property (p_no_ack) else $error("ack without request");
	a_dat_idle: assert property (p_dat_idle) else $error("read data not zero");
	a_dat_byte: assert property (p_dat_byte) else $error("upper read bits set");
	a_wo: assert property (p_wo) else $error("reload register readable");
	a_wake: assert property (p_wake) else $error("wake and irq enable differ");
	a_flag0: assert property (p_flag0) else $error("pin flag set in event mode");
	a_flag1: assert property (p_flag1) else $error("pin flag not set");
endmodule : rtbp_sva

// ==== rtbp_partner.sv ====
/* rtbp_partner: outside pulse source on the event pin and raw irq line.
 assumes: core_clk paces pulses; the event pin idles high by its pull-up. */
`timescale 1ns/1ps
module rtbp_partner (
	input wire logic core_clk,
	output logic event_input_pin,
	output logic external_irq_input
);
	initial begin
		event_input_pin = 1'b1;
		external_irq_input = 1'b0;
	end
	// falling edges spaced wide enough for the pin synchroniser
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge core_clk) event_input_pin <= 1'b0;
			repeat (4) @(posedge core_clk);
			event_input_pin <= 1'b1;
			repeat (6) @(posedge core_clk);
		end
	endtask : pulse
	// raw interrupt request held for a few cycles
	task automatic irq;
		@(posedge core_clk) external_irq_input <= 1'b1;
		repeat (4) @(posedge core_clk);
		external_irq_input <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask : irq
endmodule : rtbp_partner

// ==== rtbp_tb_top.sv ====
/* rtbp_tb_top: register-level tests of the reload timer block.
 assumes: rtbp_sva and rtbp_partner compiled before, 250 MHz clock. */
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module rtbp_tb_top;
	import rtbp_pkg::*;
	logic core_clk = 0, rst_n = 0, gpio_out = 0, gpio_oe = 0;
	rtbp_wb_req_type wb_req = '0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, ev, xirq, wave, oe, wake, xen, pflag, ovi;
	logic [7:0] d;
	int bad_count = 0, tests_run = 0, n, hi, lo;
	int pw[4] = '{512, 128, 64, 32};
	rtbp_timer rtbp_timer_i (.core_clk(core_clk), .rst_n(rst_n), .wb_req(wb_req),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .event_input_pin(ev),
		.external_irq_input(xirq), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.wave_output_pin(wave), .wave_output_oe(oe), .pin_wake_enable(wake),
		.external_irq_enable(xen), .event_pin_irq_flag(pflag), .overflow_irq(ovi));
	rtbp_partner rtbp_partner_i (.core_clk(core_clk), .event_input_pin(ev),
		.external_irq_input(xirq));
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	// one classic cycle; released after ack is sampled, or after 50 cycles without ack
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] v);
		wb_req <= '{1'b1, 1'b1, w, 4'hF, {22'h0, idx, 2'b00}, {24'h0, v}};
		n = 0;
		do begin @(posedge core_clk); n++; end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) bad_count++;
		d = wb_dat_o[7:0];
		wb_req <= '0;
		@(posedge core_clk);
	endtask : bus
	// cycles until the wave pin shows the given level
	task automatic span(input logic lvl, output int c);
		c = 0;
		while (wave !== lvl && c < 2000) begin @(posedge core_clk); c++; end
	endtask : span
	task automatic results;
		$display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		bus(0, 8'hCD, 0); `CHK(d, 8'h00)
		bus(0, 8'h10, 0); `CHK(d, 8'h00)
		`CHK(wake, 1'b1)
		`CHK(xen, 1'b1)
		rtbp_partner_i.irq(); bus(0, 8'hDC, 0); `CHK(d[2], 1'b1)
		bus(1, 8'hDA, 8'h08); bus(1, 8'hCD, 8'hFF); bus(1, 8'hDB, 8'hFF);
		bus(1, 8'hDA, 8'h88); `CHK(wake, 1'b0)
		`CHK(xen, 1'b0)
		rtbp_partner_i.irq(); bus(0, 8'hDC, 0); `CHK(d[2], 1'b0)
		rtbp_partner_i.pulse(1); bus(0, 8'hDB, 0); `CHK(d, 8'h00)
		bus(0, 8'hDC, 0); `CHK(d[0], 1'b1)
		bus(1, 8'hDC, 8'h02); bus(1, 8'hDA, 8'h8C); bus(1, 8'hCD, 8'hFE); bus(1, 8'hDB, 8'hFF);
		rtbp_partner_i.pulse(1); bus(0, 8'hDB, 0); `CHK(d, 8'hFE)
		`CHK(ovi, 1'b1)
		bus(1, 8'hCD, 8'h10); rtbp_partner_i.pulse(1); bus(0, 8'hDB, 0); `CHK(d, 8'hFF)
		bus(1, 8'hDA, 8'h0C); rtbp_partner_i.pulse(2); bus(0, 8'hDB, 0); `CHK(d, 8'hFF)
		$display("event count test done");
		bus(1, 8'hDA, 8'hF2); span(1, n); span(0, n);
		`CHK(n, 512)
		`CHK(oe, 1'b1)
		gpio_out <= 1'b1;
		bus(1, 8'hDA, 8'hF0); `CHK(oe, 1'b0)
		`CHK(wave, 1'b1)
		$display("buzzer test done");
		for (int r = 0; r < 4; r++) begin
			bus(1, 8'hDA, 8'h00); bus(1, 8'hCD, 8'h04);
			bus(1, 8'hDA, 8'hF1 | {r[1:0], 1'b0});
			span(0, n); span(1, n); span(0, hi); span(1, lo);
			`CHK(hi, 8)
			`CHK(hi + lo, pw[r])
			`CHK(oe, 1'b1)
		end
		bus(1, 8'hDA, 8'h00); `CHK(oe, 1'b0)
		`CHK(wave, 1'b1)
		$display("pwm test done");
		results();
	end
	initial begin
		#200000;
		bad_count++;
		results();
	end
endmodule : rtbp_tb_top
bind rtbp_timer rtbp_sva rtbp_sva_i (.core_clk(core_clk), .rst_n(rst_n), .wb_req(wb_req),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .external_irq_input(external_irq_input),
	.pin_wake_enable(pin_wake_enable), .external_irq_enable(external_irq_enable),
	.event_pin_irq_flag(event_pin_irq_flag));
